// file: src/servo_out_pkg.sv
/*
  Shared constants for the servo axis output block: APB register map, field
  positions, reset values, integral selector codes and timing counts.
  Assumes a 20 MHz system clock and a 32-bit APB bus.
*/
package servo_out_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h0c;
  localparam logic [7:0] OFS_MODE      = 8'h10;
  localparam logic [7:0] OFS_LIMIT     = 8'h14;
  localparam logic [7:0] OFS_DIRECT    = 8'h18;
  localparam logic [7:0] OFS_TARGET    = 8'h1c;
  localparam logic [7:0] OFS_DESIRED   = 8'h20;
  localparam logic [7:0] OFS_ACTUAL    = 8'h24;
  localparam logic [7:0] OFS_KI        = 8'h28;
  localparam logic [7:0] OFS_INTEG     = 8'h2c;
  localparam logic [7:0] OFS_OUTPUT    = 8'h30;

  // Control register fields.
  localparam int CTRL_SOFT_RESET_BIT = 0;

  // Mode register fields.
  localparam int MODE_DIRECT_BIT     = 0;
  localparam int MODE_INTSEL_LSB     = 4;

  // Status and interrupt bit positions.
  localparam int STAT_INIT_DONE_BIT  = 0;
  localparam int STAT_FERR_BIT       = 1;
  localparam int STAT_LIMIT_BIT      = 2;
  localparam int STAT_TRAJ_DONE_BIT  = 3;
  localparam int IRQ_WIDTH           = 4;

  // Integral selector codes.
  typedef enum logic [1:0] {
    integral_always_on       = 2'h0,
    integral_hold_during_move = 2'h1,
    integral_clear_and_hold  = 2'h2
  } integral_option_select_e;

  // Reset values.
  localparam logic [15:0] LIMIT_RESET     = 16'h7fff;
  localparam logic [15:0] FERR_MAX_RESET  = 16'h0400;
  localparam logic [15:0] KI_RESET        = 16'h0000;

  // Timing.
  localparam int CLK_HZ          = 20_000_000;
  localparam int INIT_TIME_US    = 100;
  localparam int INIT_CYCLES     = (INIT_TIME_US * (CLK_HZ / 1_000_000));
  localparam int SERVO_RATE_HZ   = 4000;
  localparam int SERVO_DIV       = CLK_HZ / SERVO_RATE_HZ;

endpackage : servo_out_pkg

// file: src/quad_counter.sv
/*
  Quadrature encoder counter. Synchronises the A and B pins with three
  flip-flops each and counts edges in 4x mode.
  Assumes A and B are asynchronous to clk and change no faster than clk/4.
*/
module quad_counter
  import servo_out_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         encA,
  input  wire logic         encB,
  output logic [W-1:0]      count
);

  logic [2:0] syncA;
  logic [2:0] syncB;
  logic       stableA;
  logic       stableB;

  // Three-stage synchronisers; stage one is read only by stage two.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncA <= 3'h0;
      syncB <= 3'h0;
    end else begin
      syncA <= {syncA[1:0], encA};
      syncB <= {syncB[1:0], encB};
    end
  end

  // A level counts once the second and third stages agree.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stableA <= 1'b0;
      stableB <= 1'b0;
    end else begin
      if (syncA[1] == syncA[2]) stableA <= syncA[2];
      if (syncB[1] == syncB[2]) stableB <= syncB[2];
    end
  end

  logic prevA;
  logic prevB;
  wire  edgeSeen = (stableA != prevA) || (stableB != prevB);
  // Forward when the new A differs from the old B.
  wire  countUp  = stableA ^ prevB;

  // Count keeps running in every mode, so position is always readable.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prevA <= 1'b0;
      prevB <= 1'b0;
      count <= '0;
    end else begin
      prevA <= stableA;
      prevB <= stableB;
      if (edgeSeen) count <= countUp ? count + W'(1) : count - W'(1);
    end
  end

endmodule : quad_counter

// file: src/servo_output_integral_control.sv
/*
  Single servo axis output stage: soft reset, init-gated status relay,
  output limiting, direct output mode, encoder readback and three integral
  behaviours, reached over APB.
  Assumes one 20 MHz clock, a synchronous active-high reset and an APB master.
*/
// Design decisions made here: the APB register port and the register offsets.
// Behaviour
// - A software reset command resets the control logic and the axis together.
// - After any reset all tunable settings return to their defaults.
// - The normally open relay stays off until initialization has finished.
// - In closed-loop operation the output magnitude is clamped to the programmable limit, full scale by default.
// - Direct output mode stops the loop and passes the host value to the converter.
// - In direct output mode the encoder keeps counting and stays readable.
// - In direct output mode following-error and limit checks never stop the axis.
// - The trajectory is complete when the desired position equals the target.
// - The always-on setting accumulates the integral during motion and at rest.
// - The hold setting freezes the integral while moving and resumes once trajectory complete is set.
// - The clear setting zeroes and holds the integral at motion start and resumes once trajectory complete is set.
module servo_output_integral_control
  import servo_out_pkg::*;
#(
  parameter int POS_W       = 32,
  parameter int DAC_W       = 16,
  parameter int INIT_COUNT  = INIT_CYCLES,
  parameter int SERVO_COUNT = SERVO_DIV
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              encA,
  input  wire logic              encB,
  input  wire logic              limitHit,
  output logic      [DAC_W-1:0]  dacOut,
  output logic                   relayOn,
  output logic                   axisStop,
  output logic                   irq
);

  // Soft reset and combined reset.
  logic softRst;
  wire  axisRst = sys_rst | softRst;

  // Bus decode.
  wire access   = psel & penable;
  wire wrStrobe = access & pwrite;
  wire rdStrobe = access & ~pwrite;
  wire hitCtrl  = (paddr == OFS_CTRL);
  wire hitStat  = (paddr == OFS_STATUS);
  wire hitIrqS  = (paddr == OFS_IRQ_STAT);
  wire hitIrqM  = (paddr == OFS_IRQ_MASK);
  wire hitMode  = (paddr == OFS_MODE);
  wire hitLim   = (paddr == OFS_LIMIT);
  wire hitDir   = (paddr == OFS_DIRECT);
  wire hitTgt   = (paddr == OFS_TARGET);
  wire hitDes   = (paddr == OFS_DESIRED);
  wire hitAct   = (paddr == OFS_ACTUAL);
  wire hitKi    = (paddr == OFS_KI);
  wire hitInt   = (paddr == OFS_INTEG);
  wire hitOut   = (paddr == OFS_OUTPUT);
  wire mapped   = hitCtrl | hitStat | hitIrqS | hitIrqM | hitMode | hitLim | hitDir
                | hitTgt | hitDes | hitAct | hitKi | hitInt | hitOut;

  // Zero-wait slave; unmapped addresses answer with an error.
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // The soft reset pulse lasts one cycle and clears everything below it except the limit synchroniser and prdata.
  always_ff @(posedge clk) begin
    if (sys_rst) softRst <= 1'b0;
    else         softRst <= wrStrobe & hitCtrl & pwdata[CTRL_SOFT_RESET_BIT];
  end

  // The limit switch is a pin with no relation to clk, so it passes three flops.
  // A level is taken only once stages two and three agree, which costs a few
  // cycles of latency but keeps a metastable sample out of the stop logic.
  logic [2:0] limitSync;
  logic       limitSeen;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      limitSync <= 3'h0;
      limitSeen <= 1'b0;
    end else begin
      limitSync <= {limitSync[1:0], limitHit};
      if (limitSync[1] == limitSync[2]) limitSeen <= limitSync[2];
    end
  end

  // Tunable settings all return to defaults on either reset.
  logic                    directMode;
  integral_option_select_e intSel;
  logic [15:0]             limitMag;
  logic [15:0]             kiGain;
  logic [DAC_W-1:0]        directValue;
  logic [POS_W-1:0]        targetPos;
  logic [POS_W-1:0]        desiredPos;
  logic [IRQ_WIDTH-1:0]    irqMask;

  always_ff @(posedge clk) begin
    if (axisRst) begin
      directMode  <= 1'b0;
      intSel      <= integral_always_on;
      limitMag    <= LIMIT_RESET;
      kiGain      <= KI_RESET;
      directValue <= '0;
      targetPos   <= '0;
      irqMask     <= '0;
    end else if (wrStrobe) begin
      if (hitMode) begin
        directMode <= pwdata[MODE_DIRECT_BIT];
        intSel     <= integral_option_select_e'(pwdata[MODE_INTSEL_LSB +: 2]);
      end
      if (hitLim) limitMag    <= pwdata[15:0];
      if (hitKi)  kiGain      <= pwdata[15:0];
      if (hitDir) directValue <= pwdata[DAC_W-1:0];
      if (hitTgt) targetPos   <= pwdata[POS_W-1:0];
      if (hitIrqM) irqMask    <= pwdata[IRQ_WIDTH-1:0];
    end
  end

  // Initialization counter gates the relay.
  logic [31:0] initCnt;
  logic        initDone;
  always_ff @(posedge clk) begin
    if (axisRst) begin
      initCnt  <= '0;
      initDone <= 1'b0;
    end else if (!initDone) begin
      initCnt <= initCnt + 32'h1;
      if (initCnt == 32'(INIT_COUNT - 1)) initDone <= 1'b1;
    end
  end
  assign relayOn = initDone;

  // Servo update tick divider.
  logic [31:0] tickCnt;
  logic        servoTick;
  always_ff @(posedge clk) begin
    if (axisRst) begin
      tickCnt   <= '0;
      servoTick <= 1'b0;
    end else begin
      servoTick <= (tickCnt == 32'(SERVO_COUNT - 1));
      tickCnt   <= (tickCnt == 32'(SERVO_COUNT - 1)) ? 32'h0 : tickCnt + 32'h1;
    end
  end

  // Encoder counts in every mode.
  logic [POS_W-1:0] actualPos;
  quad_counter #(
    .W (POS_W)
  ) u_enc (
    .clk     (clk),
    .sys_rst (axisRst),
    .encA    (encA),
    .encB    (encB),
    .count   (actualPos)
  );

  // Trajectory generator steps desired toward target one count per tick.
  wire trajDone = (desiredPos == targetPos);
  always_ff @(posedge clk) begin
    if (axisRst) desiredPos <= '0;
    else if (directMode) desiredPos <= actualPos; // Loop is off; track to avoid a jump later.
    else if (servoTick && !trajDone) begin
      if ($signed(targetPos - desiredPos) > 0) desiredPos <= desiredPos + POS_W'(1);
      else                                     desiredPos <= desiredPos - POS_W'(1);
    end
  end

  // Motion start is the cycle where the trajectory leaves the complete state.
  logic trajDonePrev;
  always_ff @(posedge clk) begin
    if (axisRst) trajDonePrev <= 1'b1;
    else         trajDonePrev <= trajDone;
  end
  wire motionStart = trajDonePrev & ~trajDone;

  // Following error, saturated to 16 bits.
  wire  [POS_W-1:0]  errFull = desiredPos - actualPos;
  wire  signed [15:0] errSat =
    ($signed(errFull) >  $signed(POS_W'(32767)))  ? 16'sh7fff :
    ($signed(errFull) < -$signed(POS_W'(32768)))  ? 16'sh8000 : errFull[15:0];
  wire  ferrHit = (errSat > $signed(FERR_MAX_RESET)) || (errSat < -$signed(FERR_MAX_RESET));

  // Integral accumulator with three behaviours.
  logic signed [31:0] integ;
  wire  signed [31:0] integStep = 32'(errSat) * 32'($signed({1'b0, kiGain[14:0]}));
  always_ff @(posedge clk) begin
    if (axisRst || directMode) integ <= '0;
    else begin
      case (intSel)
        integral_always_on: begin
          if (servoTick) integ <= integ + integStep;
        end
        integral_hold_during_move: begin
          if (servoTick && trajDone) integ <= integ + integStep;
        end
        integral_clear_and_hold: begin
          if (motionStart)                 integ <= '0;
          else if (servoTick && trajDone)  integ <= integ + integStep;
        end
        default: integ <= integ;
      endcase
    end
  end

  // Proportional plus integral command, then clamp to the limit.
  wire signed [31:0] cmdRaw  = 32'(errSat) * 32'sh4 + (integ >>> 8);
  wire signed [31:0] limPos  = 32'($signed({1'b0, limitMag[14:0]}));
  wire signed [31:0] cmdLim  = (cmdRaw > limPos) ? limPos : (cmdRaw < -limPos) ? -limPos : cmdRaw;
  wire [DAC_W-1:0]   next_dac = directMode ? directValue : cmdLim[DAC_W-1:0];

  // Output register updates on each servo tick, or at once in direct mode.
  always_ff @(posedge clk) begin
    if (axisRst)                      dacOut <= '0;
    else if (directMode || servoTick) dacOut <= next_dac;
  end

  // Stop request on errors only in closed-loop operation.
  always_ff @(posedge clk) begin
    if (axisRst) axisStop <= 1'b0;
    else         axisStop <= ~directMode & (ferrHit | limitSeen);
  end

  // Sticky event bits; a new event wins over a clearing write.
  logic [IRQ_WIDTH-1:0] irqStat;
  logic                 initPrev;
  wire  [IRQ_WIDTH-1:0] events;
  assign events[STAT_INIT_DONE_BIT] = initDone & ~initPrev;
  assign events[STAT_FERR_BIT]      = ~directMode & ferrHit;
  assign events[STAT_LIMIT_BIT]     = ~directMode & limitSeen;
  assign events[STAT_TRAJ_DONE_BIT] = trajDone & ~trajDonePrev;
  wire  [IRQ_WIDTH-1:0] clrBits = (wrStrobe & hitIrqS) ? pwdata[IRQ_WIDTH-1:0] : '0;
  always_ff @(posedge clk) begin
    if (axisRst) begin
      irqStat  <= '0;
      initPrev <= 1'b0;
    end else begin
      initPrev <= initDone;
      irqStat  <= (irqStat & ~clrBits) | events;
    end
  end
  assign irq = |(irqStat & irqMask);

  // Live status word.
  wire [31:0] statusWord = {28'h0, trajDone, limitSeen, ferrHit, initDone};

  // Read mux, registered output.
  wire [31:0] next_rdata =
      hitStat ? statusWord :
      hitIrqS ? {28'h0, irqStat} :
      hitIrqM ? {28'h0, irqMask} :
      hitMode ? {26'h0, intSel, 3'h0, directMode} :
      hitLim  ? {16'h0, limitMag} :
      hitDir  ? 32'(directValue) :
      hitTgt  ? 32'(targetPos) :
      hitDes  ? 32'(desiredPos) :
      hitAct  ? 32'(actualPos) :
      hitKi   ? {16'h0, kiGain} :
      hitInt  ? integ :
      hitOut  ? 32'(dacOut) : 32'h0;
  always_ff @(posedge clk) begin
    if (sys_rst)                          prdata <= 32'h0;
    else if (psel & ~penable & ~pwrite)   prdata <= next_rdata;
  end

endmodule : servo_output_integral_control

// file: dv/servo_out_asserts.sv
/*
  Port checker for the servo output block.
  Assumes the package register map and a synchronous active-high reset.
*/
module servo_out_asserts
  import servo_out_pkg::*;
#(
  parameter int INIT_COUNT = 10
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] dacOut,
  input wire logic        relayOn,
  input wire logic        axisStop,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Host writes decoded at the access edge.
  logic        wrAcc;
  logic        softHit;
  logic        cfgHit;
  logic        unmapped;
  logic [16:0] mag;
  assign wrAcc    = psel && penable && pwrite;
  assign softHit  = wrAcc && paddr == OFS_CTRL && pwdata[CTRL_SOFT_RESET_BIT];
  assign cfgHit   = wrAcc && (paddr == OFS_MODE || paddr == OFS_LIMIT);
  assign unmapped = paddr > OFS_OUTPUT || paddr[1:0] != 2'b00;
  assign mag      = dacOut[15] ? 17'h10000 - {1'b0, dacOut} : {1'b0, dacOut};

  // The output lags the shadows by up to a tick, so checks wait until calm.
  logic        direct;
  logic [15:0] limit;
  int          initCnt;
  int          calm;
  always_ff @(posedge clk) begin
    if (sys_rst || softHit) begin
      direct  <= 1'b0;
      limit   <= LIMIT_RESET;
      initCnt <= 0;
      calm    <= 0;
    end else begin
      initCnt <= initCnt + 1;
      calm    <= cfgHit ? 0 : calm + 1;
      if (wrAcc && paddr == OFS_MODE) direct <= pwdata[MODE_DIRECT_BIT];
      if (wrAcc && paddr == OFS_LIMIT) limit <= pwdata[15:0];
    end
  end

  sequence accessPhase;
    psel && penable;
  endsequence
  sequence quietOut;
    !relayOn && !irq && !axisStop && dacOut == 16'h0000;
  endsequence

  chk_ready_access: assert property (accessPhase |-> pready) else $error("pready low in access");
  chk_unmapped_err: assert property (accessPhase and unmapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (accessPhase and !unmapped |-> !pslverr) else $error("mapped access refused");
  chk_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> quietOut)
    else $error("outputs active after reset");
  chk_soft_quiet: assert property (softHit |-> ##[1:3] quietOut) else $error("soft reset ignored");
  chk_relay_wait: assert property ($rose(relayOn) |-> initCnt >= INIT_COUNT) else $error("relay early");
  chk_relay_due: assert property (initCnt == INIT_COUNT + 4 |-> relayOn) else $error("relay late");
  chk_direct_run: assert property (direct && calm > 2 |-> !axisStop) else $error("stop in direct mode");
  chk_output_clamp: assert property (!direct && calm > 20 |-> mag <= {1'b0, limit})
    else $error("output above limit");
endmodule : servo_out_asserts

bind servo_output_integral_control servo_out_asserts #(.INIT_COUNT(INIT_COUNT)) u_servo_out_asserts (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dacOut(dacOut),
  .relayOn(relayOn), .axisStop(axisStop), .irq(irq));

// file: dv/servo_amp_model.sv
/*
  Amplifier and encoder model: the shaft steps once every 16 clocks in the
  sign of the command. Assumes A leading B counts upwards.
*/
module servo_amp_model (
  input  wire logic        clk,
  input  wire logic [15:0] dacOut,
  output logic             encA,
  output logic             encB,
  output int               position
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] div = 4'h0;
  logic [1:0] ph = 2'h0;
  initial position = 0;
  // Gray order 00, 10, 11, 01; slow steps keep the pins under clk/4.
  assign encA = ph[1] ^ ph[0];
  assign encB = ph[1];
  always @(posedge clk) begin
    div <= div + 4'h1;
    if (div == 4'h0 && dacOut != 16'h0000) begin
      ph       <= dacOut[15] ? ph - 2'h1 : ph + 2'h1;
      position <= dacOut[15] ? position - 1 : position + 1;
    end
  end
endmodule : servo_amp_model

// file: dv/servo_output_integral_control_tb.sv
/*
  Self-checking bench for the servo output block.
  Assumes the amplifier model beside it and shortened init and tick counts.
*/
module servo_output_integral_control_tb;
  import servo_out_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int INIT_N = 10;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        limitHit = 1'b0;
  logic        err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, g0, a0, tgt;
  logic        pready, pslverr, encA, encB, relayOn, axisStop, irq;
  logic [15:0] dacOut, v;
  int          n_fail = 0, n_compared = 0, pos0, position, i, k;

  always #25 clk = ~clk;

  servo_output_integral_control #(.INIT_COUNT(INIT_N), .SERVO_COUNT(8)) u_servo_output_integral_control (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .encA(encA), .encB(encB),
    .limitHit(limitHit), .dacOut(dacOut), .relayOn(relayOn), .axisStop(axisStop), .irq(irq));
  servo_amp_model u_servo_amp_model (.clk(clk), .dacOut(dacOut), .encA(encA), .encB(encB), .position(position));

  function automatic logic [31:0] modeWord(input logic direct, input logic [1:0] sel);
    return {26'h0, sel, 3'h0, direct};
  endfunction : modeWord

  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : cmp

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp, m);
  endtask : rdc

  initial begin
    void'($urandom(32'h8ab1));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (INIT_N + 5) @(posedge clk);
    cmp(relayOn, 1'b1, "relay off after init");
    // Defaults, then scrambled settings undone by a soft reset.
    for (i = 0; i < 2; i++) begin
      rdc(OFS_LIMIT, {16'h0, LIMIT_RESET}, "limit default");
      rdc(OFS_MODE, modeWord(1'b0, integral_always_on), "mode default");
      rdc(OFS_KI, {16'h0, KI_RESET}, "gain default");
      apb(1'b1, OFS_LIMIT, $urandom & 32'h7fff);
      apb(1'b1, OFS_KI, $urandom & 32'hff);
      apb(1'b1, OFS_MODE, modeWord(1'b0, integral_clear_and_hold));
      apb(1'b1, OFS_CTRL, 32'h1);
      repeat (3) @(posedge clk);
      cmp(relayOn, 1'b0, "relay on in soft reset");
      repeat (INIT_N + 5) @(posedge clk);
    end
    apb(1'b0, 8'h40, 32'h0);
    cmp({31'h0, err}, 32'h1, "unmapped not refused");
    cmp(rd, 32'h0, "unmapped read data");
    // Each integral setting across a move and its completion.
    apb(1'b1, OFS_KI, 32'h1);
    for (i = 0; i < 3; i++) begin
      apb(1'b1, OFS_MODE, modeWord(1'b0, i[1:0]));
      apb(1'b0, OFS_DESIRED, 32'h0);
      tgt = rd + 32'd40 + ($urandom & 32'h7);
      apb(1'b1, OFS_TARGET, tgt);
      repeat (80) @(posedge clk);
      apb(1'b0, OFS_INTEG, 32'h0);
      g0 = rd;
      repeat (24) @(posedge clk);
      apb(1'b0, OFS_INTEG, 32'h0);
      if (i == 0) cmp({31'h0, rd !== g0}, 32'h1, "integral idle in motion");
      if (i == 1) cmp(rd, g0, "integral moved while held");
      if (i == 2) cmp(rd | g0, 32'h0, "integral not cleared");
      apb(1'b0, OFS_STATUS, 32'h0);
      cmp({31'h0, rd[STAT_TRAJ_DONE_BIT]}, 32'h0, "done while moving");
      k = 0;
      do begin
        apb(1'b0, OFS_DESIRED, 32'h0);
        k++;
      end while (rd !== tgt && k < 300);
      cmp(rd, tgt, "trajectory stalled");
      apb(1'b0, OFS_STATUS, 32'h0);
      cmp({31'h0, rd[STAT_TRAJ_DONE_BIT]}, 32'h1, "done not set");
    end
    // Limit event through the interrupt mask and clear.
    limitHit <= 1'b1;
    repeat (4) @(posedge clk);
    limitHit <= 1'b0;
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    // The write lands on the edge the task returns at; look once it has settled.
    @(negedge clk);
    cmp(irq, 1'b0, "masked interrupt");
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    cmp({31'h0, rd[STAT_LIMIT_BIT]}, 32'h1, "limit event lost");
    apb(1'b1, OFS_IRQ_MASK, 32'h4);
    @(negedge clk);
    cmp(irq, 1'b1, "unmasked interrupt");
    apb(1'b1, OFS_IRQ_STAT, 32'hf);
    @(negedge clk);
    cmp(irq, 1'b0, "interrupt not cleared");
    // Direct output with a limit fault present.
    apb(1'b1, OFS_MODE, modeWord(1'b1, integral_always_on));
    limitHit <= 1'b1;
    // Let a step still in flight through the encoder synchroniser settle first.
    repeat (40) @(posedge clk);
    apb(1'b0, OFS_ACTUAL, 32'h0);
    a0 = rd;
    pos0 = position;
    v = 16'h0100 + 16'($urandom & 32'hfff);
    apb(1'b1, OFS_DIRECT, {16'h0, v});
    for (k = 0; k < 20 && dacOut !== v; k++) @(posedge clk);
    cmp({16'h0, dacOut}, {16'h0, v}, "direct value");
    repeat (200) @(posedge clk);
    cmp(axisStop, 1'b0, "axis stopped in direct mode");
    apb(1'b1, OFS_DIRECT, 32'h0);
    repeat (40) @(posedge clk);
    apb(1'b0, OFS_ACTUAL, 32'h0);
    cmp(rd - a0, position - pos0, "encoder count");
    limitHit <= 1'b0;
    print_verdict();
  end
endmodule : servo_output_integral_control_tb
